// ===== hw/cmcoal_pkg.sv
// Purpose: shared constants and carrier types for completion coalescing
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz system clock
// Notes:   register offsets are byte addresses of aligned words
package cmcoal_pkg;
    // =========================================================
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PORT_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;

    // =========================================================
    // coalesce_control field layout
    localparam int CTL_ON_BIT = 0;
    localparam int SEL_W = 5;
    localparam int CTL_SEL_LSB = 3;
    localparam int THR_W = 8;
    localparam int CTL_THR_LSB = 8;
    localparam int TMO_W = 16;
    localparam int CTL_TMO_LSB = 16;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PORT_MASK_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PENDING_RESET = 32'h0000_0000;
    localparam int GLOBAL_IRQ_ON_BIT = 1;

    // state readback: completion_count low half, coalesce_timer high
    localparam int CNT_W = 16;
    localparam int STATE_TMR_LSB = 16;

    // =========================================================
    // time base
    localparam longint CLK_HZ = 20_000_000;
    localparam longint TICK_MS = 1;
    localparam int TICK_CYCLES = int'((CLK_HZ * TICK_MS) / 1000);

    // =========================================================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } cmcoal_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } cmcoal_axi_rsp_t;

    typedef struct packed {
        logic host_irq;
        logic msi_req;
        logic [SEL_W-1:0] msi_vector;
    } cmcoal_irq_t;
endpackage

// ===== hw/cmcoal_ms_tick.sv
// Purpose: free-running millisecond tick for the coalescing timer
// Assumes: CYCLES clock periods make one millisecond
// Notes:   tick_o is a one-cycle pulse straight from a flop
`timescale 1ns/1ns
module cmcoal_ms_tick
#(
    parameter int CYCLES = 20000
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // tick out
    output logic tick_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] div;
    wire wrap = (div == LAST);

    // divider wraps once per period and pulses the tick
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            div <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            div <= wrap ? '0 : div + ONE;
            tick_o <= wrap;
        end
    end
endmodule // cmcoal_ms_tick

// ===== hw/cmcoal_done_count.sv
// Purpose: count command completions on the selected ports each cycle
// Assumes: issue and queued vectors come from logic on the same clock
// Notes:   inc_o is combinational from current inputs and held history
`timescale 1ns/1ns
module cmcoal_done_count
#(
    parameter int NUM_PORTS = 32,
    parameter int SLOTS = 32,
    parameter int INC_W = 11
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // port state
    input wire logic [NUM_PORTS-1:0] sel_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] issue_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] queued_i,
    // results
    output logic [INC_W-1:0] inc_o,
    output logic busy_o
);
    localparam int W = NUM_PORTS * SLOTS;

    logic [W-1:0] prev_issue;
    logic [W-1:0] prev_queued;
    logic [W-1:0] done;
    logic [NUM_PORTS-1:0] port_busy;

    function automatic logic [INC_W-1:0] ones(input logic [W-1:0] v);
        logic [INC_W-1:0] n;
        n = '0;
        for (int i = 0; i < W; i++)
            n = n + INC_W'(v[i]);
        return n;
    endfunction

    // per slot completion test, qualified by port selection
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        wire [SLOTS-1:0] ci = issue_i[p*SLOTS +: SLOTS];
        wire [SLOTS-1:0] sa = queued_i[p*SLOTS +: SLOTS];
        wire [SLOTS-1:0] pci = prev_issue[p*SLOTS +: SLOTS];
        wire [SLOTS-1:0] psa = prev_queued[p*SLOTS +: SLOTS];
        // issue fall with queued clear, or any queued fall
        assign done[p*SLOTS +: SLOTS] = {SLOTS{sel_i[p]}} &
            ((pci & ~ci & ~sa) | (psa & ~sa)); // [R1]
        assign port_busy[p] = sel_i[p] & ((|ci) | (|sa)); // [R3]
    end

    // every qualifying bit adds one, not one per cycle
    assign inc_o = ones(done); // [R2]
    assign busy_o = |port_busy;

    // history for falling-edge detection
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            prev_issue <= '0;
            prev_queued <= '0;
        end
        else
        begin
            prev_issue <= issue_i;
            prev_queued <= queued_i;
        end
    end
endmodule // cmcoal_done_count

// ===== hw/cmcoal_top.sv
// Purpose: completion coalescing interrupt logic with AXI4-Lite registers
// Assumes: port vectors are synchronous to clk_sys_i
// Notes:   one aggregated interrupt on threshold, timeout or idle
// How it works
// [R1] count issue fall unqueued, or queued fall
// [R2] add one per qualifying bit
// [R3] timer runs only while selected commands outstanding
// [R4] timer steps down once per millisecond
// [R5] port selected when mask and implemented
// [R6] new port mask effective within one millisecond
// [R7] fire when count reaches nonzero threshold
// [R8] fire on decrement reaching zero
// [R9] fire on completion with selected ports idle; the code fires so only when the captured threshold is nonzero
// [R10] firing clears count, reloads timer
// [R11] same-cycle completions absorbed, count stays zero
// [R12] firing sets pending bit chosen by select
// [R13] message vector equals select field
// [R14] disabled means no coalescing interrupts
// [R15] enable rise captures fields, reloads, clears
// [R16] software keeps fields fixed while enabled
// [R17] software drops port before stopping it
// [R18] software follows setup order, enable last
// [R19] software checks vectors after enabling
// [R20] software drops port around error events
// [R21] handler clears pending, then retires commands
// [R22] host interrupt needs global enable
// [R23] counter and timer hold when idle
`timescale 1ns/1ns
module cmcoal_top
    import cmcoal_pkg::*;
#(
    parameter int NUM_PORTS = 32,
    parameter int SLOTS = 32,
    parameter int TICK_CYCLES_P = cmcoal_pkg::TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // register bus
    input wire cmcoal_pkg::cmcoal_axi_req_t axi_req_i,
    output cmcoal_pkg::cmcoal_axi_rsp_t axi_rsp_o,
    // port state from the adapter
    input wire logic [NUM_PORTS-1:0] ports_implemented_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] command_issue_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] queued_active_i,
    // interrupt out
    output cmcoal_pkg::cmcoal_irq_t irq_o
);
    import cmcoal_pkg::*;

    localparam int INC_W = $clog2(NUM_PORTS * SLOTS + 1);
    localparam logic [TMO_W-1:0] TMR_ONE = TMO_W'(1);
    localparam logic [CNT_W:0] CNT_MAX = {1'b0, {CNT_W{1'b1}}};

    // =========================================================
    // register state
    logic [DATA_W-1:0] coalesce_control;
    logic [DATA_W-1:0] coalesce_port_mask;
    logic [DATA_W-1:0] interrupt_pending;
    logic global_irq_on;
    logic on_q;
    logic [TMO_W-1:0] tmo_cap;
    logic [THR_W-1:0] thr_cap;
    logic [TMO_W-1:0] coalesce_timer;
    logic [CNT_W-1:0] completion_count;

    // =========================================================
    // bus handshake state
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;

    // =========================================================
    // field views
    wire coalesce_on = coalesce_control[CTL_ON_BIT];
    wire [SEL_W-1:0] irq_select = coalesce_control[CTL_SEL_LSB +: SEL_W];
    wire [THR_W-1:0] completion_threshold =
        coalesce_control[CTL_THR_LSB +: THR_W];
    wire [TMO_W-1:0] timeout_ms = coalesce_control[CTL_TMO_LSB +: TMO_W];

    // =========================================================
    // completion and timing inputs
    wire [NUM_PORTS-1:0] sel;
    wire [INC_W-1:0] inc;
    wire busy;
    wire tick;

    // mask is used live, so a rewrite acts on the next cycle
    assign sel = coalesce_port_mask[NUM_PORTS-1:0] &
        ports_implemented_i; // [R5] [R6]

    cmcoal_done_count #(
        .NUM_PORTS(NUM_PORTS),
        .SLOTS(SLOTS),
        .INC_W(INC_W)
    ) u_done (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(sel),
        .issue_i(command_issue_i),
        .queued_i(queued_active_i),
        .inc_o(inc),
        .busy_o(busy)
    );

    cmcoal_ms_tick #(
        .CYCLES(TICK_CYCLES_P)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    // =========================================================
    // coalescing decisions
    wire on_rise = coalesce_on & ~on_q; // [R15]
    wire run = coalesce_on & on_q;
    wire [CNT_W:0] sum = {1'b0, completion_count} + (CNT_W + 1)'(inc);
    // saturate rather than wrap so a huge burst cannot hide a hit
    wire [CNT_W-1:0] next_count_raw =
        (sum > CNT_MAX) ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
    wire thr_nz = (thr_cap != '0);
    wire step = tick & busy; // [R3] [R4]
    wire hit_thr = thr_nz &
        (next_count_raw >= CNT_W'(thr_cap)); // [R7]
    // a timeout of zero fires on the first step instead of wrapping
    wire hit_tmr = step & (coalesce_timer <= TMR_ONE); // [R8]
    wire hit_idle = thr_nz & (inc != '0) & ~busy; // [R9]
    wire fire = run & (hit_thr | hit_tmr | hit_idle); // [R14]

    // =========================================================
    // bus decode
    wire aw_take = axi_req_i.awvalid & axi_rsp_o.awready;
    wire w_take = axi_req_i.wvalid & axi_rsp_o.wready;
    wire do_wr = aw_full & w_full & ~axi_rsp_o.bvalid;
    wire ar_take = axi_req_i.arvalid & axi_rsp_o.arready;
    wire [DATA_W-1:0] bmask;
    for (genvar b = 0; b < STRB_W; b++)
    begin : g_strb
        assign bmask[b*8 +: 8] = {8{w_strb[b]}};
    end
    wire wr_ctl = do_wr & (aw_addr == OFS_CONTROL);
    wire wr_mask = do_wr & (aw_addr == OFS_PORT_MASK);
    wire wr_pend = do_wr & (aw_addr == OFS_PENDING);
    wire wr_glob = do_wr & (aw_addr == OFS_GLOBAL);
    wire wr_hit = wr_ctl | wr_mask | wr_pend | wr_glob | (do_wr &
        (aw_addr == OFS_STATE));
    wire [DATA_W-1:0] merged_ctl =
        (coalesce_control & ~bmask) | (w_data & bmask);
    wire [DATA_W-1:0] merged_mask =
        (coalesce_port_mask & ~bmask) | (w_data & bmask);
    wire [DATA_W-1:0] pend_clr = wr_pend ? (w_data & bmask) : '0;
    wire [DATA_W-1:0] pend_set =
        fire ? (DATA_W'(1) << irq_select) : '0; // [R12]
    wire [DATA_W-1:0] state_word =
        {coalesce_timer, completion_count};

    // read mux, unmapped offsets answer with an error and zero data
    logic [DATA_W-1:0] rd_word;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        if (axi_req_i.araddr == OFS_CONTROL)
            rd_word = coalesce_control;
        else if (axi_req_i.araddr == OFS_PORT_MASK)
            rd_word = coalesce_port_mask;
        else if (axi_req_i.araddr == OFS_PENDING)
            rd_word = interrupt_pending;
        else if (axi_req_i.araddr == OFS_GLOBAL)
            rd_word = DATA_W'(global_irq_on) << GLOBAL_IRQ_ON_BIT;
        else if (axi_req_i.araddr == OFS_STATE)
            rd_word = state_word;
        else
        begin
            rd_word = '0;
            rd_ok = 1'b0;
        end
    end

    // =========================================================
    // write channel: address and data taken in either order
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            axi_rsp_o.awready <= 1'b1;
            axi_rsp_o.wready <= 1'b1;
            axi_rsp_o.bvalid <= 1'b0;
            axi_rsp_o.bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr <= axi_req_i.awaddr;
                aw_full <= 1'b1;
                axi_rsp_o.awready <= 1'b0;
            end
            if (w_take)
            begin
                w_data <= axi_req_i.wdata;
                w_strb <= axi_req_i.wstrb;
                w_full <= 1'b1;
                axi_rsp_o.wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                axi_rsp_o.bvalid <= 1'b1;
                axi_rsp_o.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (axi_rsp_o.bvalid & axi_req_i.bready)
            begin
                axi_rsp_o.bvalid <= 1'b0;
                axi_rsp_o.awready <= 1'b1;
                axi_rsp_o.wready <= 1'b1;
            end
        end
    end

    // read channel: one read in flight, data registered
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            axi_rsp_o.arready <= 1'b1;
            axi_rsp_o.rvalid <= 1'b0;
            axi_rsp_o.rdata <= '0;
            axi_rsp_o.rresp <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            axi_rsp_o.arready <= 1'b0;
            axi_rsp_o.rvalid <= 1'b1;
            axi_rsp_o.rdata <= rd_word;
            axi_rsp_o.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (axi_rsp_o.rvalid & axi_req_i.rready)
        begin
            axi_rsp_o.rvalid <= 1'b0;
            axi_rsp_o.arready <= 1'b1;
        end
    end

    // =========================================================
    // software registers; a new event beats a same-cycle clear
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            coalesce_control <= CONTROL_RESET;
            coalesce_port_mask <= PORT_MASK_RESET;
            interrupt_pending <= PENDING_RESET;
            global_irq_on <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                coalesce_control <= merged_ctl;
            if (wr_mask)
                coalesce_port_mask <= merged_mask;
            if (wr_glob & w_strb[0])
                global_irq_on <= w_data[GLOBAL_IRQ_ON_BIT];
            interrupt_pending <=
                (interrupt_pending & ~pend_clr) | pend_set; // [R12]
        end
    end

    // =========================================================
    // counter and timer
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            on_q <= 1'b0;
            tmo_cap <= '0;
            thr_cap <= '0;
            coalesce_timer <= '0;
            completion_count <= '0;
        end
        else
        begin
            on_q <= coalesce_on;
            if (on_rise)
            begin
                tmo_cap <= timeout_ms; // [R15]
                thr_cap <= completion_threshold; // [R15]
                coalesce_timer <= timeout_ms; // [R15]
                completion_count <= '0; // [R15]
            end
            else if (fire)
            begin
                // completions of this cycle vanish into this interrupt
                coalesce_timer <= tmo_cap; // [R10]
                completion_count <= '0; // [R10] [R11]
            end
            else if (run)
            begin
                completion_count <= next_count_raw; // [R1]
                if (step)
                    coalesce_timer <= coalesce_timer - TMR_ONE; // [R4]
            end
            // disabled, or idle between ticks: both hold [R23]
        end
    end

    // =========================================================
    // interrupt outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            irq_o <= '0;
        end
        else
        begin
            irq_o.host_irq <= global_irq_on &
                (|interrupt_pending); // [R22]
            irq_o.msi_req <= fire & global_irq_on; // [R13] [R22]
            irq_o.msi_vector <= irq_select; // [R13]
        end
    end
endmodule // cmcoal_top

// ===== tb/cmcoal_top_sva.sv
// Purpose: port-level checks for completion coalescing
// Assumes: bench offers write address and data together, full strobes
// Notes: shadows of control and global follow taken writes
`timescale 1ns/1ns
module cmcoal_top_sva
    import cmcoal_pkg::*;
#(
    parameter int NUM_PORTS = 32,
    parameter int SLOTS = 32,
    parameter int TICK_CYCLES_P = 20
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire cmcoal_pkg::cmcoal_axi_req_t axi_req_i,
    input wire cmcoal_pkg::cmcoal_axi_rsp_t axi_rsp_o,
    input wire logic [NUM_PORTS-1:0] ports_implemented_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] command_issue_i,
    input wire logic [NUM_PORTS*SLOTS-1:0] queued_active_i,
    input wire cmcoal_pkg::cmcoal_irq_t irq_o
);
    import cmcoal_pkg::*;
    // ======
    // shadows; they lead the design's registers by one edge
    logic [DATA_W-1:0] sh_ctl;
    logic sh_glb;
    wire wr_go = axi_req_i.awvalid & axi_rsp_o.awready
        & axi_req_i.wvalid & axi_rsp_o.wready;
    wire sh_on = sh_ctl[CTL_ON_BIT];
    wire [SEL_W-1:0] sh_sel = sh_ctl[CTL_SEL_LSB +: SEL_W];

    // capture control and global words as they are taken
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            sh_ctl <= '0;
            sh_glb <= 1'b0;
        end
        else if (wr_go && axi_req_i.awaddr == OFS_CONTROL)
            sh_ctl <= axi_req_i.wdata;
        else if (wr_go && axi_req_i.awaddr == OFS_GLOBAL)
            sh_glb <= axi_req_i.wdata[GLOBAL_IRQ_ON_BIT];
    end

    // ======
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_reset_idle: assert property ($fell(sys_rst_i) |-> axi_rsp_o.awready
        && axi_rsp_o.arready && !axi_rsp_o.bvalid && !irq_o.host_irq)
        else $error("outputs not idle after reset");
    chk_write_resp: assert property (wr_go |-> ##2 axi_rsp_o.bvalid)
        else $error("write response late");
    chk_read_resp: assert property (axi_req_i.arvalid && axi_rsp_o.arready
        |=> axi_rsp_o.rvalid)
        else $error("read data late");
    chk_aw_drop: assert property (axi_req_i.awvalid && axi_rsp_o.awready
        |=> !axi_rsp_o.awready)
        else $error("awready stayed high");
    chk_b_done: assert property (axi_rsp_o.bvalid && axi_req_i.bready
        |=> !axi_rsp_o.bvalid)
        else $error("bvalid stayed after handshake");
    chk_host_gate: assert property (
        irq_o.host_irq |-> $past(sh_glb, 2))
        else $error("host interrupt without global enable");
    chk_msi_off: assert property (
        irq_o.msi_req |-> $past(sh_on, 2))
        else $error("interrupt while coalescing off");
    chk_msi_vec: assert property (
        irq_o.msi_req |-> irq_o.msi_vector == $past(sh_sel, 2))
        else $error("message vector differs from select");
    chk_msi_status: assert property (
        irq_o.msi_req |=> irq_o.host_irq)
        else $error("message without pending status");
endmodule // cmcoal_top_sva

bind cmcoal_top cmcoal_top_sva #(.NUM_PORTS(NUM_PORTS), .SLOTS(SLOTS),
    .TICK_CYCLES_P(TICK_CYCLES_P)) cmcoal_top_sva_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o), .ports_implemented_i(ports_implemented_i),
    .command_issue_i(command_issue_i), .queued_active_i(queued_active_i),
    .irq_o(irq_o));

// ===== tb/tb.sv
// Purpose: self-checking bench for completion coalescing
// Assumes: 4 ports of 8 slots, 20-cycle millisecond
// Notes: expected count and pending come from a bench model
`timescale 1ns/1ns
module tb;
    import cmcoal_pkg::*;
    localparam int TK = 20;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    cmcoal_axi_req_t req = '0;
    cmcoal_axi_rsp_t rsp;
    cmcoal_irq_t irq;
    logic [3:0] pi = 4'h7;
    logic [31:0] ci = '0;
    logic [31:0] qa = '0;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 89099;
    int m_cnt = 0;
    int m_thr = 0;
    logic m_on = 1'b0;
    logic [3:0] m_sel = '0;
    logic [31:0] m_pend = '0;
    logic [4:0] sel;
    logic [31:0] rd;
    longint t1;

    // ======
    always #25 clk_sys_i = ~clk_sys_i;

    cmcoal_top #(.NUM_PORTS(4), .SLOTS(8), .TICK_CYCLES_P(TK))
    cmcoal_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .axi_req_i(req), .axi_rsp_o(rsp), .ports_implemented_i(pi),
        .command_issue_i(ci), .queued_active_i(qa), .irq_o(irq));

    // ======
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        $display("mismatch %0t wait ran out", $time);
        final_report();
    endtask

    // write: outputs sampled at the falling edge, acted on at the rising
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic at;
        logic wt;
        logic bv;
        logic [1:0] r;
        @(posedge clk_sys_i);
        {req.awaddr, req.wdata, req.wstrb} <= {a, d, 4'hf};
        {req.awvalid, req.wvalid, req.bready} <= 3'b111;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_sys_i);
            at = rsp.awready & req.awvalid;
            wt = rsp.wready & req.wvalid;
            {bv, r} = {rsp.bvalid, rsp.bresp};
            @(posedge clk_sys_i);
            if (at)
                req.awvalid <= 1'b0;
            if (wt)
                req.wvalid <= 1'b0;
            if (bv)
            begin
                req.bready <= 1'b0;
                chk(r, er);
                return;
            end
        end
        hang();
    endtask

    // read into rd; response code compared here
    task automatic rdw(input logic [7:0] a, input logic [1:0] er);
        logic at;
        logic rv;
        logic [1:0] r;
        @(posedge clk_sys_i);
        req.araddr <= a;
        {req.arvalid, req.rready} <= 2'b11;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_sys_i);
            at = rsp.arready & req.arvalid;
            {rv, rd, r} = {rsp.rvalid, rsp.rdata, rsp.rresp};
            @(posedge clk_sys_i);
            if (at)
                req.arvalid <= 1'b0;
            if (rv)
            begin
                req.rready <= 1'b0;
                chk(r, er);
                return;
            end
        end
        hang();
    endtask

    // new port vectors plus the model's view of count and firing
    task automatic st(input logic [31:0] c, input logic [31:0] q,
        input int inc);
        bit busy;
        busy = 1'b0;
        for (int p = 0; p < 4; p++)
            if (m_sel[p] && (c[p*8 +: 8] != 0 || q[p*8 +: 8] != 0))
                busy = 1'b1;
        @(posedge clk_sys_i);
        ci <= c;
        qa <= q;
        m_cnt += inc;
        if (m_on && m_thr != 0 && inc > 0 && (m_cnt >= m_thr || !busy))
        begin
            m_cnt = 0;
            m_pend |= 32'h1 << sel;
        end
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic wait_irq();
        // skip the edge the caller woke on; host_irq is not settled there
        @(negedge clk_sys_i);
        for (int i = 0; i < 100 && irq.host_irq !== 1'b1; i++)
            @(negedge clk_sys_i);
        if (irq.host_irq !== 1'b1)
            hang();
    endtask

    // ======
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // reset values, unmapped and read-only places
        for (int a = 0; a <= 16; a += 4)
        begin
            rdw(8'(a), RESP_OKAY);
            chk(rd, 32'h0);
        end
        rdw(8'h14, RESP_SLVERR);
        wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
        wr(OFS_STATE, 32'hffff_ffff, RESP_OKAY);
        rdw(OFS_STATE, RESP_OKAY);
        chk(rd, 32'h0);
        $display("test regs done");
        // threshold: only ports 0 and 2 are both masked and implemented
        sel = 5'(4 + ($unsigned($random(seed)) % 28));
        wr(OFS_GLOBAL, 32'h2, RESP_OKAY);
        wr(OFS_PORT_MASK, 32'hd, RESP_OKAY);
        m_sel = 4'h5;
        st(32'h15, 32'h0128_ff04, 0);
        {m_thr, m_on, m_cnt} = {32'd5, 1'b1, 32'd0};
        wr(OFS_CONTROL, {16'h03e8, 8'h05, sel, 3'b001}, RESP_OKAY);
        st(32'h14, 32'h0128_ff04, 1);
        st(32'h14, 32'h0000_0004, 2);
        st(32'h10, 32'h0000_0004, 0);
        rdw(OFS_STATE, RESP_OKAY);
        chk(rd[15:0], m_cnt[15:0]);
        st(32'h0, 32'h0, 2);
        rdw(OFS_PENDING, RESP_OKAY);
        chk(rd, m_pend);
        rdw(OFS_STATE, RESP_OKAY);
        chk(rd, {16'h03e8, m_cnt[15:0]});
        wr(OFS_PENDING, m_pend, RESP_OKAY);
        m_pend = '0;
        $display("test threshold done");
        // idle: a lone completion with nothing left outstanding
        st(32'h2, 32'h0, 0);
        st(32'h0, 32'h0, 1);
        rdw(OFS_PENDING, RESP_OKAY);
        chk(rd, m_pend);
        wr(OFS_PENDING, m_pend, RESP_OKAY);
        m_pend = '0;
        // dropped port: its completions neither count nor fire
        wr(OFS_PORT_MASK, 32'h4, RESP_OKAY);
        m_sel = 4'h4;
        st(32'h3, 32'h0, 0);
        st(32'h0, 32'h0, 0);
        rdw(OFS_PENDING, RESP_OKAY);
        chk(rd, m_pend);
        wr(OFS_PORT_MASK, 32'hd, RESP_OKAY);
        m_sel = 4'h5;
        $display("test idle done");
        // timer: interval between two expiries is the whole timeout
        wr(OFS_CONTROL, 32'h0, RESP_OKAY);
        st(32'h1, 32'h0, 0);
        wr(OFS_CONTROL, {16'h0003, 8'h00, sel, 3'b001}, RESP_OKAY);
        wait_irq();
        t1 = $time;
        wr(OFS_PENDING, 32'h1 << sel, RESP_OKAY);
        wait_irq();
        chk(32'(($time - t1) / 50), 32'(3 * TK));
        wr(OFS_PENDING, 32'h1 << sel, RESP_OKAY);
        st(32'h0, 32'h0, 1);
        repeat (100) @(posedge clk_sys_i);
        rdw(OFS_STATE, RESP_OKAY);
        chk(rd, {16'h0003, 16'h0001});
        $display("test timer done");
        // disabled: busy ports past the timeout raise nothing
        wr(OFS_CONTROL, 32'h0, RESP_OKAY);
        wr(OFS_CONTROL, {16'h0001, 8'h00, sel, 3'b001}, RESP_OKAY);
        wr(OFS_CONTROL, 32'h0, RESP_OKAY);
        rdw(OFS_STATE, RESP_OKAY);
        chk(rd, {16'h0001, 16'h0000});
        st(32'h1, 32'h0, 0);
        repeat (100) @(posedge clk_sys_i);
        rdw(OFS_PENDING, RESP_OKAY);
        chk(rd, 32'h0);
        chk(32'(irq.host_irq), 32'h0);
        $display("test disabled done");
        final_report();
    end
endmodule // tb
